// ---- hw/sensor_readout.sv ----
// Digital row and column readout sequencing of the sensor, with serial configuration.
// Assumes all control pins come from an external timing controller unrelated to clk_sys.
//
// Notes on behaviour
// - Backup mode tracks while active, stores at end.
// - 32-bit configuration word field layout.
// - Row direction bit one scans bottom to top.
// - All-zero word gives default readout.
// - Latch moves shifted word into active configuration.
// - Column sync initialises the column address.
// - Line-end output at end of column scan.
// - Check output shows data through shift chain.
// - Column step clock sets pixel rate.
// - First row after sync is start times two.
// - First column after sync is start times two.
// - Single output: two pixels per column period.
`timescale 1ns/10ps
module sensor_readout
  import readout_pkg::*;
#(
  parameter int ROWS = ARRAY_ROWS,
  parameter int COLS = ARRAY_COLS
)
(
  // System clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Serial configuration link
  input wire logic cfg_shift_clk,
  input wire logic cfg_shift_data,
  // Readout control pins
  input wire ctrl_pins_t ctrl_pins,
  // Readout state and test outputs
  output readout_state_t readout,
  output logic line_end,
  output logic cfg_check,
  output config_t active_cfg
);

  localparam int PIN_W = $bits(ctrl_pins_t);
  localparam logic [ADDR_W-1:0] ROW_LAST = ADDR_W'(ROWS - 1);
  localparam logic [ADDR_W-1:0] COL_END = ADDR_W'(COLS);

  logic [CFG_W-1:0] shift_word;
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  ctrl_pins_t pins;
  ctrl_pins_t pins_d_reg;
  logic row_clk_rise;
  logic col_clk_rise;
  logic latch_rise;
  logic hold_end;

  config_t cfg_reg;
  config_t cfg_next;
  readout_state_t rd_reg;
  readout_state_t rd_next;
  logic line_end_reg;
  logic line_end_next;
  logic [ADDR_W-1:0] col_step;
  logic [ADDR_W-1:0] col_after;
  logic [ADDR_W-1:0] col_remaining;

  ////////////////////////////////////////////////////////////////////////////////
  // Shift chain on the serial clock.
  config_shift_chain u_chain
  (
    .cfg_shift_clk(cfg_shift_clk),
    .cfg_shift_data(cfg_shift_data),
    .shift_word(shift_word),
    .cfg_check(cfg_check)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Every control pin passes two flip-flops; edges are found on the second stage only.
  // The stages carry no reset, so a pin held high across reset gives no false edge after it.
  always_ff @(posedge clk_sys)
  begin
    sync1_reg <= ctrl_pins;
    sync2_reg <= sync1_reg;
    pins_d_reg <= sync2_reg;
  end

  assign pins = ctrl_pins_t'(sync2_reg);
  assign col_clk_rise = pins.col_step_clk & ~pins_d_reg.col_step_clk;
  assign row_clk_rise = pins.row_step_clk & ~pins_d_reg.row_step_clk;
  assign latch_rise = pins.cfg_latch & ~pins_d_reg.cfg_latch;
  assign hold_end = pins.column_track_hold_n & ~pins_d_reg.column_track_hold_n;

  ////////////////////////////////////////////////////////////////////////////////
  // Active configuration.
  always_comb
  begin
    cfg_next = cfg_reg;
    if (latch_rise)
    begin
      cfg_next = config_t'(shift_word);
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cfg_reg <= config_t'(CFG_RESET);
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Row and column addressing, pixel selection and column sample state.
  assign col_step = cfg_reg.subsample_en ? COL_STEP_SUB : COL_STEP;
  assign col_after = cfg_reg.col_reverse ? rd_reg.col_addr - col_step : rd_reg.col_addr + col_step;
  assign col_remaining = COL_END - rd_reg.col_addr;

  always_comb
  begin
    rd_next = rd_reg;
    line_end_next = line_end_reg;
    // Row sync loads start times two
    if (pins.row_sync)
    begin
      rd_next.row_addr = {cfg_reg.row_start, 1'b0};
    end
    else if (row_clk_rise)
    begin
      if (cfg_reg.row_reverse)
      begin
        rd_next.row_addr = rd_reg.row_addr - ROW_STEP;
      end
      else
      begin
        rd_next.row_addr = (rd_reg.row_addr == ROW_LAST) ? '0 : rd_reg.row_addr + ROW_STEP;
      end
    end
    if (pins.col_sync)
    begin
      rd_next.col_addr = {cfg_reg.col_start, 1'b0};
    end
    else if (col_clk_rise)
    begin
      rd_next.col_addr = col_after;
    end
    // Line end at last column group
    if (pins.col_sync || row_clk_rise)
    begin
      line_end_next = 1'b0;
    end
    else if (col_clk_rise)
    begin
      if (cfg_reg.col_reverse ? (rd_reg.col_addr < col_step) : (col_remaining <= (col_step << 1)))
      begin
        line_end_next = 1'b1;
      end
    end
    // With a single output the low half of the clock selects the next pixel; two outputs present both pixels at once
    if (cfg_reg.two_outputs)
    begin
      rd_next.pix_a = rd_reg.col_addr;
      rd_next.pix_b = cfg_reg.col_reverse ? rd_reg.col_addr - PIX_NEXT : rd_reg.col_addr + PIX_NEXT;
    end
    else
    begin
      rd_next.pix_b = '0;
      if (pins.col_step_clk)
      begin
        rd_next.pix_a = rd_reg.col_addr;
      end
      else
      begin
        rd_next.pix_a = cfg_reg.col_reverse ? rd_reg.col_addr - PIX_NEXT : rd_reg.col_addr + PIX_NEXT;
      end
    end
    // Track while active, store at release
    rd_next.tracking = ~pins.column_track_hold_n;
    if (hold_end)
    begin
      rd_next.held_row = rd_reg.row_addr;
    end
    rd_next.averaging_active = pins.averaging_pulse & cfg_reg.averaging_en & pins.column_track_hold_n;
    rd_next.buses_precharged = pins.output_bus_precharge_a | pins.output_bus_precharge_b;
    rd_next.line_reset = pins.row_deselect | pins.column_precharge;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rd_reg <= '0;
      line_end_reg <= 1'b0;
    end
    else
    begin
      rd_reg <= rd_next;
      line_end_reg <= line_end_next;
    end
  end

  assign readout = rd_reg;
  assign line_end = line_end_reg;
  assign active_cfg = cfg_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the readout logic.
  a_latch_copies_word: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(pins.cfg_latch) |=> (active_cfg == config_t'($past(shift_word))))
    else $error("Latch did not copy the shifted word.");

  a_cfg_holds_between: assert property (
    @(posedge clk_sys) disable iff (reset)
    !latch_rise |=> $stable(active_cfg))
    else $error("Active configuration changed without a latch.");

  a_reset_zero_cfg: assert property (
    @(posedge clk_sys)
    reset |=> (active_cfg == config_t'(CFG_RESET)) && (readout.row_addr == '0) && !line_end)
    else $error("Reset did not give the default configuration.");

  a_row_sync_load: assert property (
    @(posedge clk_sys) disable iff (reset)
    pins.row_sync ##1 $stable(active_cfg) |-> (readout.row_addr == {active_cfg.row_start, 1'b0}))
    else $error("Row address not start times two after sync.");

  a_row_step_dir: assert property (
    @(posedge clk_sys) disable iff (reset)
    (row_clk_rise && !pins.row_sync && cfg_reg.row_reverse && !latch_rise) |=>
      (readout.row_addr == $past(readout.row_addr) - ROW_STEP))
    else $error("Reversed row scan did not step down.");

  a_col_sync_load: assert property (
    @(posedge clk_sys) disable iff (reset)
    (pins.col_sync && !latch_rise) |=> (readout.col_addr == {active_cfg.col_start, 1'b0}))
    else $error("Column address not start times two after sync.");

  a_pixel_pair_sel: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!cfg_reg.two_outputs && !cfg_reg.col_reverse && !pins.col_step_clk && !latch_rise && !pins.col_sync)
      |=> (readout.pix_a == $past(readout.col_addr) + PIX_NEXT))
    else $error("Low clock half did not select the second pixel.");

  a_line_end_clear: assert property (
    @(posedge clk_sys) disable iff (reset)
    (line_end && pins.col_sync) |=> !line_end)
    else $error("Line end not cleared by column sync.");

  a_track_store_row: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(pins.column_track_hold_n) |=> (readout.held_row == $past(readout.row_addr)) && !readout.tracking)
    else $error("Column data not stored at end of track.");

  a_held_row_stable: assert property (
    @(posedge clk_sys) disable iff (reset)
    !hold_end |=> $stable(readout.held_row))
    else $error("Stored row changed while tracking continued.");

  a_col_step_fwd: assert property (
    @(posedge clk_sys) disable iff (reset)
    (col_clk_rise && !pins.col_sync && !active_cfg.col_reverse) |=>
      (readout.col_addr == $past(readout.col_addr) + $past(active_cfg.subsample_en ? COL_STEP_SUB : COL_STEP)))
    else $error("Column address did not step up on the column clock.");

  a_col_step_rev: assert property (
    @(posedge clk_sys) disable iff (reset)
    (col_clk_rise && !pins.col_sync && active_cfg.col_reverse) |=>
      (readout.col_addr == $past(readout.col_addr) - $past(active_cfg.subsample_en ? COL_STEP_SUB : COL_STEP)))
    else $error("Column address did not step down on the column clock.");

  a_line_end_src: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(line_end) |-> $past(col_clk_rise))
    else $error("Line end rose without a column step.");

  a_row_clear_end: assert property (
    @(posedge clk_sys) disable iff (reset)
    row_clk_rise |=> !line_end)
    else $error("Line end not cleared by the row clock.");

  a_row_step_fwd: assert property (
    @(posedge clk_sys) disable iff (reset)
    (row_clk_rise && !pins.row_sync && !active_cfg.row_reverse && (readout.row_addr != ROW_LAST)) |=>
      (readout.row_addr == $past(readout.row_addr) + ROW_STEP))
    else $error("Forward row scan did not step up.");

  a_two_out_pair: assert property (
    @(posedge clk_sys) disable iff (reset)
    (active_cfg.two_outputs && !active_cfg.col_reverse) |=>
      (readout.pix_a == $past(readout.col_addr)) && (readout.pix_b == $past(readout.col_addr) + PIX_NEXT))
    else $error("Two outputs did not present the pixel pair.");

  a_single_out_high: assert property (
    @(posedge clk_sys) disable iff (reset)
    (!active_cfg.two_outputs && pins.col_step_clk) |=>
      (readout.pix_a == $past(readout.col_addr)) && (readout.pix_b == '0))
    else $error("High clock half did not select the first pixel.");

  a_avg_needs_en: assert property (
    @(posedge clk_sys) disable iff (reset)
    !active_cfg.averaging_en |=> !readout.averaging_active)
    else $error("Averaging active while disabled in the configuration.");

endmodule

// ---- hw/readout_pkg.sv ----
// Constants, field layouts and carrier types for the row readout and serial configuration block.
// Assumes a single system clock domain plus a free-standing serial shift clock domain.
package readout_pkg;

  // Configuration word layout, bit positions.
  localparam int CFG_W = 32;
  localparam int CFG_ROW_DIR_BIT = 0;
  localparam int CFG_ROW_START_LSB = 1;
  localparam int CFG_AVG_EN_BIT = 11;
  localparam int CFG_SUBSAMPLE_BIT = 12;
  localparam int CFG_COL_DIR_BIT = 13;
  localparam int CFG_COL_START_LSB = 14;
  localparam int CFG_OUT_COUNT_BIT = 24;
  localparam int CFG_DAC_LSB = 25;
  localparam int START_W = 10;
  localparam int DAC_W = 7;

  // Reset value of the active configuration.
  localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;

  // Address width and array size.
  localparam int ADDR_W = 11;
  localparam int ARRAY_ROWS = 2048;
  localparam int ARRAY_COLS = 2048;

  // Column step in pixels per column clock period, plain and subsampled, then row step and next-pixel offset.
  localparam logic [ADDR_W-1:0] COL_STEP = 11'h002;
  localparam logic [ADDR_W-1:0] COL_STEP_SUB = 11'h004;
  localparam logic [ADDR_W-1:0] ROW_STEP = 11'h001;
  localparam logic [ADDR_W-1:0] PIX_NEXT = 11'h001;

  // Synchroniser depth for pin inputs.
  localparam int SYNC_STAGES = 2;

  // Active configuration, packed so that a cast of the word lands every field on its bit.
  typedef struct packed {
    logic [DAC_W-1:0] dac_level;
    logic two_outputs;
    logic [START_W-1:0] col_start;
    logic col_reverse;
    logic subsample_en;
    logic averaging_en;
    logic [START_W-1:0] row_start;
    logic row_reverse;
  } config_t;

  // Readout control pins driven by the external timing controller.
  typedef struct packed {
    logic cfg_latch;
    logic col_step_clk;
    logic col_sync;
    logic row_step_clk;
    logic row_sync;
    logic row_deselect;
    logic column_precharge;
    logic column_track_hold_n;
    logic averaging_pulse;
    logic output_bus_precharge_a;
    logic output_bus_precharge_b;
  } ctrl_pins_t;

  // Readout state presented by the sensor logic.
  typedef struct packed {
    logic [ADDR_W-1:0] row_addr;
    logic [ADDR_W-1:0] col_addr;
    logic [ADDR_W-1:0] pix_a;
    logic [ADDR_W-1:0] pix_b;
    logic [ADDR_W-1:0] held_row;
    logic tracking;
    logic averaging_active;
    logic buses_precharged;
    logic line_reset;
  } readout_state_t;

endpackage

// ---- hw/config_shift_chain.sv ----
// Serial configuration shift chain, clocked by the serial shift clock.
// Assumes the shift clock stops once the word is in, so the parallel word is static when latched.
`timescale 1ns/10ps
module config_shift_chain
  import readout_pkg::*;
(
  // Serial link
  input wire logic cfg_shift_clk,
  input wire logic cfg_shift_data,
  // Parallel word and chain check
  output logic [CFG_W-1:0] shift_word,
  output logic cfg_check
);

  logic [CFG_W-1:0] chain_reg;
  logic [CFG_W-1:0] chain_next;
  logic check_reg;
  logic check_next;

  ////////////////////////////////////////////////////////////////////////////////
  // First bit in ends at bit 0 after 32 shifts, so the last bit sent lands on bit 31.
  // Chain check output
  always_comb
  begin
    chain_next = {cfg_shift_data, chain_reg[CFG_W-1:1]};
    check_next = chain_reg[0];
  end

  always_ff @(posedge cfg_shift_clk)
  begin
    chain_reg <= chain_next;
    check_reg <= check_next;
  end

  assign shift_word = chain_reg;
  assign cfg_check = check_reg;

endmodule

// ---- verification/readout_ctrl_model.sv ----
// Timing controller model that drives the sensor's control pins and its serial configuration link.
// Assumes clk_sys runs freely; pin changes land 1 ns after a clk_sys rise, except the precharge and deselect releases in next_line.
`timescale 1ns/10ps
module readout_ctrl_model
  import readout_pkg::*;
(
  // System clock
  input wire logic clk_sys,
  // Serial link and control pins
  output logic cfg_shift_clk,
  output logic cfg_shift_data,
  output ctrl_pins_t pins
);
  ////////////////////////////////////////////////////////////
  initial
  begin
    cfg_shift_clk = 1'b0;
    cfg_shift_data = 1'b0;
    pins = '0;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic send_cfg(input logic [CFG_W-1:0] w);
    step(1);
    for (int k = 0; k < CFG_W; k++)
    begin
      cfg_shift_data = w[k];
      #15 cfg_shift_clk = 1'b1;
      #15 cfg_shift_clk = 1'b0;
    end
    cfg_shift_data = ~w[CFG_W-1];
    step(2);
    pins.cfg_latch = 1'b1;
    step(4);
    pins.cfg_latch = 1'b0;
    step(4);
  endtask

  // Sync spans a row clock rise.
  task automatic row_sync();
    pins.row_sync = 1'b1;
    step(3);
    pins.row_step_clk = 1'b1;
    step(3);
    pins.row_step_clk = 1'b0;
    pins.row_sync = 1'b0;
    step(5);
  endtask

  task automatic col_sync();
    pins.col_sync = 1'b1;
    step(3);
    pins.col_sync = 1'b0;
    step(5);
  endtask

  task automatic col_half(input logic lvl);
    pins.averaging_pulse = 1'b0;
    pins.col_step_clk = lvl;
    step(5);
  endtask

  // Line select pulses, each line started by a row step.
  task automatic next_line(input logic backup, input logic avg);
    pins.row_step_clk = 1'b1;
    pins.row_deselect = 1'b1;
    pins.column_precharge = 1'b1;
    pins.output_bus_precharge_a = 1'b1;
    pins.output_bus_precharge_b = 1'b1;
    pins.column_track_hold_n = 1'b0;
    #5 pins.output_bus_precharge_a = 1'b0;
    pins.output_bus_precharge_b = 1'b0;
    #15 pins.row_deselect = 1'b0;
    pins.column_precharge = 1'b0;
    #180 pins.column_track_hold_n = backup;
    pins.averaging_pulse = avg;
    step(4);
    pins.row_step_clk = 1'b0;
    step(3);
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the sensor readout block, stimulated through the controller model.
// Assumes the controller model owns every pin; the bench resets, sequences and checks.
`timescale 1ns/10ps
module tb
  import readout_pkg::*;
;
  logic clk_sys;
  logic reset;
  logic cfg_shift_clk;
  logic cfg_shift_data;
  ctrl_pins_t pins;
  readout_state_t readout;
  logic line_end;
  logic cfg_check;
  config_t active_cfg;
  int error_cnt;
  int cmp_count;

  ////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  readout_ctrl_model ctl_u (.clk_sys(clk_sys), .cfg_shift_clk(cfg_shift_clk), .cfg_shift_data(cfg_shift_data),
    .pins(pins));

  sensor_readout dut_u (.clk_sys(clk_sys), .reset(reset), .cfg_shift_clk(cfg_shift_clk),
    .cfg_shift_data(cfg_shift_data), .ctrl_pins(pins), .readout(readout), .line_end(line_end),
    .cfg_check(cfg_check), .active_cfg(active_cfg));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic do_reset(input int n);
    @(posedge clk_sys);
    #1 reset = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask

  ////////////////////////////////////////////////////////////
  initial
  begin
    error_cnt = 0;
    cmp_count = 0;
    reset = 1'b1;
    do_reset(12);
    chk(active_cfg, CFG_RESET);
    ctl_u.send_cfg(32'hAAFF_080A);
    chk(active_cfg, 32'hAAFF_080A);
    ctl_u.row_sync();
    chk(readout.row_addr, 11'h00A);
    ctl_u.next_line(1'b0, 1'b0);
    chk(readout.row_addr, 11'h00B);
    chk(readout.tracking, 1'h1);
    chk(readout.line_reset, 1'h0);
    chk(readout.buses_precharged, 1'h0);
    ctl_u.next_line(1'b1, 1'b1);
    chk(readout.tracking, 1'h0);
    chk(readout.averaging_active, 1'h1);
    chk(readout.held_row, 11'h00C);
    ctl_u.col_sync();
    chk(readout.col_addr, 11'h7F8);
    chk(readout.pix_a, 11'h7F9);
    ctl_u.col_half(1'b1);
    chk(readout.col_addr, 11'h7FA);
    chk(readout.pix_a, 11'h7FA);
    chk(readout.pix_b, 11'h000);
    chk(line_end, 1'h0);
    ctl_u.col_half(1'b0);
    chk(readout.pix_a, 11'h7FB);
    ctl_u.col_half(1'b1);
    ctl_u.col_half(1'b0);
    ctl_u.col_half(1'b1);
    chk(readout.col_addr, 11'h7FE);
    chk(line_end, 1'h1);
    ctl_u.col_sync();
    chk(line_end, 1'h0);
    chk(readout.col_addr, 11'h7F8);
    ctl_u.send_cfg(32'h0100_9007);
    chk(active_cfg, 32'h0100_9007);
    chk(cfg_check, 1'h1);
    ctl_u.row_sync();
    chk(readout.row_addr, 11'h006);
    ctl_u.next_line(1'b0, 1'b0);
    chk(readout.row_addr, 11'h005);
    ctl_u.col_half(1'b0);
    ctl_u.col_sync();
    chk(readout.col_addr, 11'h004);
    ctl_u.col_half(1'b1);
    chk(readout.col_addr, 11'h008);
    chk(readout.pix_b, 11'h009);
    do_reset(3);
    chk(active_cfg, CFG_RESET);
    chk(readout.col_addr, 11'h000);
    ctl_u.send_cfg(32'h0000_0000);
    chk(cfg_check, 1'h0);
    chk(active_cfg, 32'h0000_0000);
    ctl_u.send_cfg(32'h0000_6000);
    chk(active_cfg, 32'h0000_6000);
    chk(cfg_check, 1'h0);
    ctl_u.col_half(1'b0);
    ctl_u.col_sync();
    chk(readout.col_addr, 11'h002);
    chk(readout.pix_a, 11'h001);
    ctl_u.col_half(1'b1);
    chk(readout.col_addr, 11'h000);
    chk(readout.pix_a, 11'h000);
    chk(line_end, 1'h0);
    ctl_u.col_half(1'b0);
    chk(readout.pix_a, 11'h7FF);
    finish_test();
  end

  // The whole sequence needs well under 60 us, so 200 us means a hang.
  initial
  begin
    #200000;
    error_cnt++;
    finish_test();
  end
endmodule
